// [rtl/gtpg_top.sv]
// Top level of the GPS timing pulse generator
`timescale 1ns/100ps
module gtpg_top
	import gtpg_pkg::*;
#(
	parameter int P_HIGH_CYC = HIGH_CYC,
	parameter int P_MSG_CYC  = MSG_CYC
)
(
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rstn,
	input  wire logic                    i_epoch,
	input  wire logic                    i_epoch_second,
	input  wire logic       [TIME_W-1:0] i_gps_time,
	input  wire logic              [1:0] i_update_sel,
	input  wire logic                    i_pos_valid,
	input  wire logic              [3:0] i_num_sv,
	input  wire logic                    i_cfg_load,
	input  wire logic        [PER_W-1:0] i_cfg_period,
	input  wire logic signed [OFF_W-1:0] i_cfg_offset,
	input  wire logic                    i_cfg_falling,
	output logic                         o_pulse,
	output logic                         o_timing_valid,
	output logic                         o_cfg_reject,
	output logic                         o_cfg_busy,
	output logic                         o_msg_strobe,
	output logic            [TIME_W-1:0] o_msg_time
);

	localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(P_HIGH_CYC - 1);
	localparam logic [CNT_W-1:0] MSG_LAST  = CNT_W'(P_MSG_CYC - 1);
	localparam logic [CYC_W-1:0] CYC_ONE   = 35'h000000001;
	localparam logic [CYC_W-1:0] CYC_ZERO  = 35'h000000000;

	gtpg_state_type          state_r;
	gtpg_state_type          state_nxt;
	logic        [PER_W-1:0] period_r;
	logic signed [OFF_W-1:0] offset_r;
	logic                    falling_r;
	logic              [1:0] sel_r;
	logic        [CYC_W-1:0] phase_r;
	logic        [PER_W-1:0] new_per_r;
	logic signed [OFF_W-1:0] new_off_r;
	logic                    new_fall_r;
	logic              [1:0] new_sel_r;
	logic                    mod_start_r;
	logic        [PER_W-1:0] acc_r;
	logic                    arm_r;
	logic        [CYC_W-1:0] cnt_r;
	logic       [TIME_W-1:0] ep_time_r;
	logic       [TIME_W-1:0] pulse_time_r;
	logic                    act_r;
	logic                    out_r;
	logic        [CNT_W-1:0] high_cnt_r;
	logic                    pend_r;
	logic        [CNT_W-1:0] msg_cnt_r;
	logic                    strobe_r;
	logic       [TIME_W-1:0] msg_time_r;
	logic                    valid_r;
	logic                    reject_r;
	logic                    mod_done;
	logic        [CYC_W-1:0] mod_result;

	// Configuration acceptance checks
	wire take_w  = i_cfg_load && (state_r != ST_PHASE);
	wire range_w = (i_cfg_period >= PERIOD_MIN_U)
		&& (i_cfg_period <= PERIOD_MAX_U)
		&& (i_cfg_offset <= OFFSET_MAX_S)
		&& (i_cfg_offset >= OFFSET_MIN_S);
	wire mult_w  = gtpg_is_multiple(i_cfg_period, i_update_sel);
	wire good_w  = take_w && range_w && mult_w;
	wire bad_w   = take_w && !(range_w && mult_w);

	// Offset and period converted to clock cycles for the phase fold
	wire signed [CYC_W-1:0] off_ext_w = CYC_W'(new_off_r);
	wire signed [CYC_W-1:0] off_mul_w = off_ext_w * CYC_W'(OFF_NUM);
	wire signed [CYC_W-1:0] off_cyc_w = off_mul_w >>> OFF_SHIFT;
	wire        [CYC_W-1:0] per_cyc_w = CYC_W'(new_per_r)
		* CYC_W'(UNIT_CYC);

	// Epoch accumulation in period units at the update interval
	wire [PER_W-1:0] int_w = gtpg_interval(sel_r);
	wire [PER_W-1:0] inc_w = acc_r + int_w;
	wire arm_al_w = (state_r == ST_ARM) && i_epoch_second;
	wire run_al_w = (state_r == ST_RUN) && (inc_w >= period_r);
	wire aligned_w = !good_w && i_epoch && (arm_al_w || run_al_w);

	// Pulse firing: at the epoch for zero phase, else after countdown
	wire now_w  = aligned_w && (phase_r == CYC_ZERO);
	wire late_w = arm_r && (cnt_r == CYC_ONE);
	wire fire_w = now_w || late_w;
	wire [TIME_W-1:0] fire_time_w = now_w ? i_gps_time : ep_time_r;

	// Pulse and message timers
	wire high_end_w = (high_cnt_r == HIGH_LAST);
	wire act_nxt    = fire_w || (act_r && !high_end_w);
	wire msg_end_w  = (msg_cnt_r == MSG_LAST);
	wire strobe_nxt = pend_r && !fire_w && msg_end_w;
	wire fall_nxt   = (mod_done && state_r == ST_PHASE) ? new_fall_r
		: falling_r;

	// Phase of the pulse inside its period
	gtpg_mod #(
		.W (CYC_W)
	) u_mod (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_start   (mod_start_r),
		.i_value   (off_cyc_w),
		.i_modulus (per_cyc_w),
		.o_busy    (),
		.o_done    (mod_done),
		.o_result  (mod_result)
	);

	// State sequencing
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_PHASE:
				if (mod_done)
					state_nxt = ST_ARM;
			ST_ARM:
				if (good_w)
					state_nxt = ST_PHASE;
				else if (aligned_w)
					state_nxt = ST_RUN;
			ST_RUN:
				if (good_w)
					state_nxt = ST_PHASE;
		endcase
	end

	// Configuration registers with default settings at reset
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_r     <= ST_ARM;
			period_r    <= PERIOD_RST_U;
			offset_r    <= OFFSET_RST_S;
			falling_r   <= 1'b0;
			sel_r       <= SEL_1HZ;
			phase_r     <= CYC_ZERO;
			new_per_r   <= PERIOD_RST_U;
			new_off_r   <= OFFSET_RST_S;
			new_fall_r  <= 1'b0;
			new_sel_r   <= SEL_1HZ;
			mod_start_r <= 1'b0;
			reject_r    <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			mod_start_r <= good_w;
			reject_r    <= bad_w;
			if (good_w)
			begin
				new_per_r  <= i_cfg_period;
				new_off_r  <= i_cfg_offset;
				new_fall_r <= i_cfg_falling;
				new_sel_r  <= i_update_sel;
			end
			if (mod_done && state_r == ST_PHASE)
			begin
				period_r  <= new_per_r;
				offset_r  <= new_off_r;
				falling_r <= new_fall_r;
				sel_r     <= new_sel_r;
				phase_r   <= mod_result;
			end
		end
	end

	// Epoch accumulator and phase countdown
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			acc_r     <= '0;
			arm_r     <= 1'b0;
			cnt_r     <= CYC_ZERO;
			ep_time_r <= '0;
		end
		else
		begin
			if (aligned_w || state_r != ST_RUN)
				acc_r <= '0;
			else if (i_epoch)
				acc_r <= inc_w;
			if (good_w || late_w)
				arm_r <= 1'b0;
			else if (aligned_w && !now_w)
				arm_r <= 1'b1;
			if (aligned_w)
				cnt_r <= phase_r;
			else if (arm_r)
				cnt_r <= cnt_r - CYC_ONE;
			if (aligned_w)
				ep_time_r <= i_gps_time;
		end
	end

	// Pulse output with selectable polarity
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			act_r        <= 1'b0;
			out_r        <= 1'b0;
			high_cnt_r   <= '0;
			pulse_time_r <= '0;
		end
		else
		begin
			act_r <= act_nxt;
			out_r <= act_nxt ^ fall_nxt;
			if (fire_w)
				high_cnt_r <= '0;
			else if (act_r)
				high_cnt_r <= high_cnt_r + 24'h000001;
			if (fire_w)
				pulse_time_r <= fire_time_w;
		end
	end

	// Position/velocity message strobe after each pulse
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pend_r     <= 1'b0;
			msg_cnt_r  <= '0;
			strobe_r   <= 1'b0;
			msg_time_r <= '0;
			valid_r    <= 1'b0;
		end
		else
		begin
			pend_r   <= fire_w || (pend_r && !msg_end_w);
			strobe_r <= strobe_nxt;
			if (fire_w)
				msg_cnt_r <= '0;
			else if (pend_r)
				msg_cnt_r <= msg_cnt_r + 24'h000001;
			if (strobe_nxt)
				msg_time_r <= pulse_time_r;
			valid_r <= i_pos_valid && (i_num_sv >= MIN_SV);
		end
	end

	assign o_pulse        = out_r;
	assign o_timing_valid = valid_r;
	assign o_cfg_reject   = reject_r;
	assign o_cfg_busy     = (state_r == ST_PHASE);
	assign o_msg_strobe   = strobe_r;
	assign o_msg_time     = msg_time_r;

	// Cycles since the last aligned epoch, read only by assertions
	logic [CYC_W-1:0] since_r;
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			since_r <= CYC_ZERO;
		else if (aligned_w)
			since_r <= CYC_ONE;
		else
			since_r <= since_r + CYC_ONE;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	sequence seq_good_load;
		good_w;
	endsequence
	sequence seq_fold_done;
		o_cfg_busy [*2] ##[0:30] !o_cfg_busy;
	endsequence

	// Checks of pulse timing, setting handling and message strobe
	zero_phase_fire_a: assert property (
		now_w |=> act_r && o_pulse != falling_r)
		else $error("zero phase epoch did not start a pulse");
	phase_delay_a: assert property (late_w |-> since_r == phase_r)
		else $error("delayed pulse not at phase after epoch");
	pulse_width_a: assert property (
		$fell(act_r) |-> $past(high_cnt_r) == HIGH_LAST)
		else $error("pulse high time wrong");
	pulse_hold_a: assert property ($rose(act_r) |=> act_r [*8])
		else $error("pulse dropped too early");
	polarity_a: assert property (o_pulse == (act_r ^ falling_r))
		else $error("pulse polarity wrong");
	valid_qual_a: assert property (
		o_timing_valid |-> $past(i_pos_valid)
		&& $past(i_num_sv) >= MIN_SV)
		else $error("timing qualified without fix");
	cfg_range_a: assert property (
		state_r == ST_RUN |-> period_r >= PERIOD_MIN_U
		&& period_r <= PERIOD_MAX_U && offset_r <= OFFSET_MAX_S
		&& offset_r >= OFFSET_MIN_S)
		else $error("running with out of range setting");
	cfg_reject_a: assert property (
		bad_w |=> o_cfg_reject && !o_cfg_busy
		&& period_r == $past(period_r) && offset_r == $past(offset_r))
		else $error("bad setting not rejected");
	cfg_commit_a: assert property (seq_good_load |=> seq_fold_done)
		else $error("phase fold did not finish in time");
	msg_delay_a: assert property (
		o_msg_strobe |-> $past(pend_r) && $past(msg_cnt_r) == MSG_LAST)
		else $error("message strobe not at latency");
	msg_time_a: assert property (
		o_msg_strobe |-> o_msg_time == $past(pulse_time_r))
		else $error("message time not that of pulse");
	epoch_step_a: assert property (
		state_r == ST_RUN && i_epoch && !aligned_w && !good_w
		|=> acc_r == $past(inc_w))
		else $error("epoch accumulator missed an interval");

endmodule

// [rtl/gtpg_pkg.sv]
// Constants, types and helper functions of the GPS timing pulse generator
// Overview of operation
// - Default: one pulse per second, rising edge
// - Pulse period from 0.05 to 99.95 seconds
// - Signed offset within plus or minus 999.9999 ms
// - Selectable edge marks the epoch, rising default
// - Pulse stays active between one and two ms
// - Active edge within one microsecond of target
// - Timing qualified only with fix, four satellites
// - Message time is that of the pulse before it
// - Message strobe about 40 ms after pulse
// - Update intervals of 1, 0.1 or 0.05 seconds
package gtpg_pkg;

	// Clock rate of the system timebase
	localparam int unsigned CLK_HZ = 125_000_000;

	// Field widths
	localparam int PER_W  = 11;
	localparam int OFF_W  = 25;
	localparam int CYC_W  = 35;
	localparam int TIME_W = 32;
	localparam int CNT_W  = 24;

	// Period is held in units of 50 ms
	localparam int unsigned PERIOD_UNIT_MS = 50;
	localparam int unsigned UNIT_CYC = PERIOD_UNIT_MS * (CLK_HZ / 1000);
	localparam logic [PER_W-1:0] PERIOD_MIN_U = 11'h001;
	localparam logic [PER_W-1:0] PERIOD_MAX_U = 11'h7cf;
	localparam logic [PER_W-1:0] PERIOD_RST_U = 11'h014;

	// Offset is held in signed units of 100 ns
	localparam int unsigned OFFSET_UNIT_NS = 100;
	localparam logic signed [OFF_W-1:0] OFFSET_MAX_S = 25'sh098967f;
	localparam logic signed [OFF_W-1:0] OFFSET_MIN_S = 25'sh1676981;
	localparam logic signed [OFF_W-1:0] OFFSET_RST_S = 25'sh0000000;
	// Offset cycles = units * OFF_NUM >> OFF_SHIFT
	localparam int OFF_NUM = 2 * OFFSET_UNIT_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int OFF_SHIFT = 1;

	// Pulse high time and message latency
	localparam int unsigned HIGH_US = 1500;
	localparam int unsigned HIGH_CYC = HIGH_US * (CLK_HZ / 1_000_000);
	localparam int unsigned MSG_LAT_MS = 40;
	localparam int unsigned MSG_CYC = MSG_LAT_MS * (CLK_HZ / 1000);

	// Minimum satellites tracked for qualified timing
	localparam logic [3:0] MIN_SV = 4'h4;

	// Update rate selection codes and intervals in period units
	localparam logic [1:0] SEL_1HZ  = 2'h0;
	localparam logic [1:0] SEL_10HZ = 2'h1;
	localparam logic [1:0] SEL_20HZ = 2'h2;
	localparam logic [PER_W-1:0] INT_1HZ_U  = 11'h014;
	localparam logic [PER_W-1:0] INT_10HZ_U = 11'h002;
	localparam logic [PER_W-1:0] INT_20HZ_U = 11'h001;

	// Configuration state
	typedef enum logic [1:0] {ST_PHASE, ST_ARM, ST_RUN} gtpg_state_type;

	// Update interval of a rate selection
	function automatic logic [PER_W-1:0] gtpg_interval(input logic [1:0] sel);
		logic [PER_W-1:0] r;
		r = INT_1HZ_U;
		if (sel == SEL_10HZ)
			r = INT_10HZ_U;
		else if (sel == SEL_20HZ)
			r = INT_20HZ_U;
		return r;
	endfunction

	// Period falls on a computation epoch of the selected rate
	function automatic logic gtpg_is_multiple(input logic [PER_W-1:0] per,
		input logic [1:0] sel);
		logic r;
		r = ((per % INT_1HZ_U) == 11'h000);
		if (sel == SEL_10HZ)
			r = (per[0] == 1'b0);
		else if (sel == SEL_20HZ)
			r = 1'b1;
		return r;
	endfunction

endpackage

// [rtl/gtpg_mod.sv]
// Sequential modulo unit that folds a signed value into [0, modulus)
`timescale 1ns/100ps
module gtpg_mod
	import gtpg_pkg::*;
#(
	parameter int W = CYC_W
)
(
	input  wire logic                i_clk_sys,
	input  wire logic                i_rstn,
	input  wire logic                i_start,
	input  wire logic signed [W-1:0] i_value,
	input  wire logic        [W-1:0] i_modulus,
	output logic                     o_busy,
	output logic                     o_done,
	output logic             [W-1:0] o_result
);

	logic signed [W-1:0] acc_r;
	logic signed [W-1:0] acc_nxt;
	logic                busy_r;
	logic                busy_nxt;
	logic                done_r;
	logic                done_nxt;

	// One add or subtract of the modulus per cycle until in range
	wire               neg_w   = acc_r[W-1];
	wire               over_w  = !neg_w && (acc_r >= $signed(i_modulus));
	wire signed [W-1:0] add_w  = acc_r + $signed(i_modulus);
	wire signed [W-1:0] sub_w  = acc_r - $signed(i_modulus);

	// Next state of the fold
	always_comb
	begin
		acc_nxt  = acc_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (i_start)
		begin
			acc_nxt  = i_value;
			busy_nxt = 1'b1;
		end
		else if (busy_r)
		begin
			if (neg_w)
				acc_nxt = add_w;
			else if (over_w)
				acc_nxt = sub_w;
			else
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	// Registers
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			acc_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			acc_r  <= acc_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign o_busy   = busy_r;
	assign o_done   = done_r;
	assign o_result = acc_r;

endmodule

// [dv/gtpg_peer.sv]
// Peripheral model that time-tags timing pulses and position messages
`timescale 1ns/100ps
module gtpg_peer
	import gtpg_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic       [31:0] i_cyc,
	input  wire logic              i_falling,
	input  wire logic              i_pulse,
	input  wire logic              i_tag,
	input  wire logic [TIME_W-1:0] i_time,
	output int                     o_pulses,
	output int                     o_rise_cyc,
	output int                     o_width,
	output int                     o_tags,
	output int                     o_tag_cyc,
	output logic      [TIME_W-1:0] o_tag_time
);
	logic act_r;
	initial
	begin
		act_r = 1'b0;
		o_pulses = 0;
		o_rise_cyc = 0;
		o_width = 0;
		o_tags = 0;
		o_tag_cyc = 0;
		o_tag_time = '0;
	end
	// Sample just after the falling edge, once a polarity change has landed
	always @(negedge i_clk_sys)
	begin
		#1;
		if (((i_pulse ^ i_falling) === 1'b1) && !act_r)
		begin
			o_pulses++;
			o_rise_cyc = i_cyc;
		end
		if (((i_pulse ^ i_falling) === 1'b0) && act_r)
			o_width = i_cyc - o_rise_cyc;
		act_r = ((i_pulse ^ i_falling) === 1'b1);
		// Time-tag each pulse from the message that follows it
		if (i_tag === 1'b1)
		begin
			o_tags++;
			o_tag_cyc = i_cyc;
			o_tag_time = i_time;
		end
	end
endmodule

// [dv/gtpg_top_tb.sv]
// Self-checking testbench of the GPS timing pulse generator
`timescale 1ns/100ps
module gtpg_top_tb;
	import gtpg_pkg::*;
	// Shortened high time and message latency; rise lands on the epoch edge
	localparam int HI = 20;
	localparam int MSG = 40;
	localparam int LAT = 0;
	localparam int LIMIT = 20000;
	logic                    i_clk_sys;
	logic                    i_rstn;
	logic                    i_epoch;
	logic                    i_epoch_second;
	logic       [TIME_W-1:0] i_gps_time;
	logic              [1:0] i_update_sel;
	logic                    i_pos_valid;
	logic              [3:0] i_num_sv;
	logic                    i_cfg_load;
	logic        [PER_W-1:0] i_cfg_period;
	logic signed [OFF_W-1:0] i_cfg_offset;
	logic                    i_cfg_falling;
	logic                    o_pulse;
	logic                    o_timing_valid;
	logic                    o_cfg_reject;
	logic                    o_cfg_busy;
	logic                    o_msg_strobe;
	logic       [TIME_W-1:0] o_msg_time;
	logic             [31:0] cyc = 32'h0;
	logic                    fall;
	int                      n_errors;
	int                      samples_checked;
	int                      ep;
	int                      np;
	int                      pulses;
	int                      rise;
	int                      width;
	int                      tags;
	int                      tag_cyc;
	logic       [TIME_W-1:0] tag_time;

	gtpg_top #(.P_HIGH_CYC(HI), .P_MSG_CYC(MSG)) gtpg_top_i (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_epoch(i_epoch),
		.i_epoch_second(i_epoch_second), .i_gps_time(i_gps_time),
		.i_update_sel(i_update_sel), .i_pos_valid(i_pos_valid),
		.i_num_sv(i_num_sv), .i_cfg_load(i_cfg_load),
		.i_cfg_period(i_cfg_period), .i_cfg_offset(i_cfg_offset),
		.i_cfg_falling(i_cfg_falling), .o_pulse(o_pulse),
		.o_timing_valid(o_timing_valid), .o_cfg_reject(o_cfg_reject),
		.o_cfg_busy(o_cfg_busy), .o_msg_strobe(o_msg_strobe),
		.o_msg_time(o_msg_time));

	gtpg_peer gtpg_peer_i (
		.i_clk_sys(i_clk_sys), .i_cyc(cyc), .i_falling(fall),
		.i_pulse(o_pulse), .i_tag(o_msg_strobe), .i_time(o_msg_time),
		.o_pulses(pulses), .o_rise_cyc(rise), .o_width(width),
		.o_tags(tags), .o_tag_cyc(tag_cyc), .o_tag_time(tag_time));

	// Clock of 8 ns
	initial
	begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end

	// Cycle count and hang guard
	always @(posedge i_clk_sys)
	begin
		cyc <= cyc + 32'h1;
		if (cyc == LIMIT)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("errors %0d, checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check_bit(input logic got, input logic exp, string m);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
		string m);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %0h", $time, m, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask

	// One-cycle epoch strobe; ep is the edge that samples it
	task automatic epoch(input logic sec, input logic [TIME_W-1:0] t);
		i_epoch = 1'b1;
		i_epoch_second = sec;
		i_gps_time = t;
		ep = cyc + 1;
		tick(1);
		i_epoch = 1'b0;
		i_epoch_second = 1'b0;
		tick(99);
	endtask

	// Apply a setting and see it refused or folded in
	task automatic load(input logic [PER_W-1:0] per,
		input logic signed [OFF_W-1:0] off, input logic fl,
		input logic [1:0] sel, input logic rej);
		logic r;
		int k;
		i_cfg_period = per;
		i_cfg_offset = off;
		i_cfg_falling = fl;
		i_update_sel = sel;
		i_cfg_load = 1'b1;
		tick(1);
		i_cfg_load = 1'b0;
		r = o_cfg_reject;
		tick(1);
		r = r | o_cfg_reject;
		check_bit(r, rej, "reject");
		for (k = 0; k < 60 && o_cfg_busy !== 1'b0; k++)
			tick(1);
		check_bit(o_cfg_busy, 1'b0, "busy stuck");
		if (!rej)
			fall = fl;
	endtask

	// Check the last pulse against its epoch and phase
	task automatic check_pulse(input int ph, input logic [TIME_W-1:0] t);
		check_word(rise - ep, ph + LAT, "edge time");
		check_word(width, HI, "high time");
		check_word(tag_cyc - rise, MSG, "msg latency");
		check_word(tag_time, t, "msg time");
	endtask

	initial
	begin
		fall = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		i_rstn = 1'b0;
		i_epoch = 1'b0;
		i_epoch_second = 1'b0;
		i_gps_time = '0;
		i_update_sel = SEL_1HZ;
		i_pos_valid = 1'b0;
		i_num_sv = 4'h0;
		i_cfg_load = 1'b0;
		i_cfg_period = PERIOD_RST_U;
		i_cfg_offset = OFFSET_RST_S;
		i_cfg_falling = 1'b0;
		tick(6);
		i_rstn = 1'b1;
		tick(2);
		// Defaults: rising pulse each second, idle low
		check_bit(o_pulse, 1'b0, "idle level");
		epoch(1'b0, 32'h0000_1111);
		check_word(pulses, 0, "pulse without second");
		epoch(1'b1, 32'h0000_2222);
		check_pulse(0, 32'h0000_2222);
		epoch(1'b0, 32'h0000_3333);
		check_pulse(0, 32'h0000_3333);
		check_word(pulses, 2, "pulse count");
		$display("test defaults done");
		// Qualified timing needs a fix and four satellites
		i_pos_valid = 1'b1;
		i_num_sv = MIN_SV;
		tick(2);
		check_bit(o_timing_valid, 1'b1, "valid at four");
		i_num_sv = 4'h3;
		tick(2);
		check_bit(o_timing_valid, 1'b0, "valid at three");
		i_num_sv = 4'hc;
		i_pos_valid = 1'b0;
		tick(2);
		check_bit(o_timing_valid, 1'b0, "valid no fix");
		$display("test qualify done");
		// Out-of-range and off-epoch settings are refused, settings at the limits taken
		load(11'h000, 25'sh0, 1'b0, SEL_1HZ, 1'b1);
		load(11'h7d0, 25'sh0, 1'b0, SEL_1HZ, 1'b1);
		load(11'h014, 25'sh0989680, 1'b0, SEL_1HZ, 1'b1);
		load(11'h014, 25'sh1676980, 1'b0, SEL_1HZ, 1'b1);
		load(11'h002, 25'sh0, 1'b0, SEL_1HZ, 1'b1);
		load(11'h003, 25'sh0, 1'b0, SEL_10HZ, 1'b1);
		load(11'h002, 25'sh0, 1'b0, 2'h3, 1'b1);
		load(PERIOD_MAX_U, 25'sh0, 1'b0, SEL_20HZ, 1'b0);
		load(11'h014, OFFSET_MAX_S, 1'b0, SEL_1HZ, 1'b0);
		load(11'h014, OFFSET_MIN_S, 1'b0, SEL_1HZ, 1'b0);
		$display("test limits done");
		// Falling edge marks the epoch
		load(11'h014, 25'sh0, 1'b1, SEL_1HZ, 1'b0);
		tick(2);
		check_bit(o_pulse, 1'b1, "falling idle");
		np = pulses;
		epoch(1'b1, 32'h0000_4444);
		check_pulse(0, 32'h0000_4444);
		check_word(pulses - np, 1, "falling count");
		$display("test polarity done");
		// Eight offset units delay the edge by 100 cycles
		load(11'h014, 25'sh0000008, 1'b0, SEL_1HZ, 1'b0);
		epoch(1'b1, 32'h0000_5555);
		tick(60);
		check_pulse(100, 32'h0000_5555);
		$display("test offset done");
		// Fast update rates: every second epoch, then every epoch
		load(11'h004, 25'sh0, 1'b0, SEL_10HZ, 1'b0);
		np = pulses;
		epoch(1'b1, 32'h0000_6666);
		epoch(1'b0, 32'h0000_6667);
		epoch(1'b0, 32'h0000_6668);
		epoch(1'b0, 32'h0000_6669);
		check_word(pulses - np, 2, "10 Hz count");
		load(PERIOD_MIN_U, 25'sh0, 1'b0, SEL_20HZ, 1'b0);
		np = pulses;
		epoch(1'b1, 32'h0000_7777);
		epoch(1'b0, 32'h0000_7778);
		check_word(pulses - np, 2, "20 Hz count");
		check_pulse(0, 32'h0000_7778);
		check_word(tags, pulses, "one tag per pulse");
		$display("test rates done");
		tally_and_finish();
	end
endmodule
